// ### verilog/flash_self_write_pkg.sv
// Package with register map, field layout, constants and types of the flash self-write sequencer
package flash_self_write_pkg;

    // Register byte offsets on the Wishbone bus (one 32-bit word each)
    localparam logic [7:0] OFS_DATA_LOW   = 8'h00;
    localparam logic [7:0] OFS_DATA_HIGH  = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW   = 8'h08;
    localparam logic [7:0] OFS_ADDR_HIGH  = 8'h0C;
    localparam logic [7:0] OFS_CONTROL    = 8'h10;
    localparam logic [7:0] OFS_UNLOCK_KEY = 8'h14;

    // Control register bit positions
    localparam int BIT_CFG_SELECT = 6;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_ERASE      = 4;
    localparam int BIT_SEQ_ERROR  = 3;
    localparam int BIT_PROG_EN    = 2;
    localparam int BIT_WRITE_GO   = 1;
    localparam int BIT_READ_GO    = 0;

    // Unlock key pattern and progress of the key sequence
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] KEY_NONE   = 2'h0;
    localparam logic [1:0] KEY_HALF   = 2'h1;
    localparam logic [1:0] KEY_OPEN   = 2'h2;

    // Blank content of a write latch and of an erased word
    localparam logic [13:0] LATCH_BLANK = 14'h3FFF;
    localparam int          ROW_WORDS   = 16;

    // Configuration space word addresses
    localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
    localparam logic [14:0] CFG_DEVICE_ID    = 15'h0006;
    localparam logic [14:0] CFG_CONFIG_ONE   = 15'h0007;
    localparam logic [14:0] CFG_CONFIG_TWO   = 15'h0008;

    // Device and revision code, value is arbitrary
    localparam logic [13:0] DEVICE_ID_WORD = 14'h1234;

    // Reset values
    localparam logic [7:0]  RST_ADDR_LOW = 8'h00;
    localparam logic [6:0]  RST_ADDR_HIGH = 7'h00;

    // Self-timed operation durations
    localparam int CLK_PERIOD_NS   = 50;
    localparam int ROW_PROG_NS     = 2000;
    localparam int ROW_ERASE_NS    = 2000;
    localparam int ROW_PROG_CYCLES  = (ROW_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ROW_ERASE_CYCLES = (ROW_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W           = 8;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_PROG  = 3'b010,
        ST_WAIT  = 3'b011,
        ST_DONE  = 3'b100
    } seq_state_t;

endpackage : flash_self_write_pkg

// ### verilog/flash_self_write_control.sv
// Flash self-write sequencer with Wishbone register slave
//
// Contract
// - Config select picks config space or array
// - User IDs writable; device/config words read-only
// - Invalid config read clears both data bytes
// - Low data byte holds word bits 7:0
// - High data byte bits 5:0, top zero
// - Low address byte holds address 7:0
// - High address bits 14:8, bit 7 one
// - Latch-only start just loads addressed latch
// - Normal start loads latch then programs row
// - Erase select overrides latch-only bit
// - Erase select erases array row, not config space; cleared when done
// - Every start attempt sets sequence error flag
// - Program enable low inhibits program and erase
// - Start self-timed, set-only, hardware cleared
// - Read start fetches word, hardware cleared
// - Address and control reset to zero
// - Latches return to blank after array program or erase
// - Sixteen-word rows; low bits select latch
//
// Register access over Wishbone and the address map were chosen for this implementation.
module flash_self_write_control
    import flash_self_write_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Flash array port
    input  wire logic [13:0] flash_rdata_i,
    input  wire logic [13:0] config_word_one_i,
    input  wire logic [13:0] config_word_two_i,
    output logic      [14:0] flash_addr_o,
    output logic      [13:0] flash_wdata_o,
    output logic             flash_prog_o,
    output logic             flash_erase_o,
    output logic             busy_o
);

    // Complete state of the block
    typedef struct packed {
        logic [7:0]             dat_lo;     // Word bits 7:0
        logic [5:0]             dat_hi;     // Word bits 13:8
        logic [7:0]             adr_lo;     // Address bits 7:0
        logic [6:0]             adr_hi;     // Address bits 14:8
        logic                   config_space_select;       // Config space select
        logic                   latch_load_only;       // Latch load only
        logic                   free;       // Erase select
        logic                   err;        // Sequence error flag
        logic                   program_enable;       // Program enable
        logic                   wr;         // Program/erase start
        logic                   rd;         // Read start
        logic [1:0]             key;        // Unlock progress
        seq_state_t             fsm;        // Sequencer state
        logic                   arr;        // Array operation in flight
        logic [3:0]             idx;        // Latch walk index
        logic [WAIT_W-1:0]      cnt;        // Self-timed wait
        logic [15:0][13:0]      latch;      // Row write latches
        logic [3:0][13:0]       uid;        // User ID words
        logic                   ack;        // Bus acknowledge
        logic [31:0]            rdat;       // Bus read data
        logic [14:0]            f_adr;      // Flash address
        logic [13:0]            f_wdat;     // Flash write data
        logic                   f_prog;     // Flash word program strobe
        logic                   f_erase;    // Flash row erase strobe
    } state_t;

    // Reset image
    localparam state_t RESET_STATE = '{
        adr_lo:  RST_ADDR_LOW,
        adr_hi:  RST_ADDR_HIGH,
        fsm:     ST_IDLE,
        latch:   {ROW_WORDS{LATCH_BLANK}},
        uid:     {4{LATCH_BLANK}},
        default: '0
    };

    state_t     q;          // Registered state
    state_t     d;          // Next state
    logic       bus_req;    // New bus request this cycle
    logic       wr_try;     // Software tries to set the start bit
    logic       wr_go;      // Start accepted
    logic [7:0] key_byte;   // Byte written to the key register

    // Valid read address in config space
    function automatic logic cfg_readable(input logic [14:0] a);
        cfg_readable = (a <= CFG_USER_ID_LAST) || (a == CFG_DEVICE_ID)
                    || (a == CFG_CONFIG_ONE) || (a == CFG_CONFIG_TWO);
    endfunction : cfg_readable

    // Word returned by a config space read
    function automatic logic [13:0] cfg_word(input state_t s, input logic [14:0] a);
        if (a <= CFG_USER_ID_LAST) begin
            cfg_word = s.uid[a[1:0]];
        end else if (a == CFG_DEVICE_ID) begin
            cfg_word = DEVICE_ID_WORD;
        end else if (a == CFG_CONFIG_ONE) begin
            cfg_word = config_word_one_i;
        end else if (a == CFG_CONFIG_TWO) begin
            cfg_word = config_word_two_i;
        end else begin
            cfg_word = 14'h0000;
        end
    endfunction : cfg_word

    // Register read view
    function automatic logic [7:0] reg_view(input state_t s, input logic [7:0] a);
        case (a)
            OFS_DATA_LOW:  reg_view = s.dat_lo;
            OFS_DATA_HIGH: reg_view = {2'h0, s.dat_hi};
            OFS_ADDR_LOW:  reg_view = s.adr_lo;
            OFS_ADDR_HIGH: reg_view = {1'b1, s.adr_hi};
            OFS_CONTROL:   reg_view = {1'b1, s.config_space_select, s.latch_load_only, s.free,
                                       s.err, s.program_enable, s.wr, s.rd};
            default:       reg_view = 8'h00;
        endcase
    endfunction : reg_view

    // Next-state logic
    always_comb begin
        d        = q;
        bus_req  = wb_cyc_i && wb_stb_i && !q.ack;
        key_byte = wb_dat_i[7:0];
        wr_try   = 1'b0;
        wr_go    = 1'b0;
        if (ce_i) begin
            d.ack     = 1'b0;
            d.f_prog  = 1'b0;
            d.f_erase = 1'b0;
            // Read completes one cycle after its start
            if (q.rd && q.fsm == ST_IDLE) begin
                d.rd = 1'b0;
                if (q.config_space_select) begin
                    if (cfg_readable({q.adr_hi, q.adr_lo})) begin
                        {d.dat_hi, d.dat_lo} = cfg_word(q, {q.adr_hi, q.adr_lo});
                    end else begin
                        d.dat_hi = 6'h00;
                        d.dat_lo = 8'h00;
                    end
                end else begin
                    {d.dat_hi, d.dat_lo} = flash_rdata_i;
                end
            end
            // Bus access, acknowledged one cycle after request
            if (bus_req) begin
                d.ack  = 1'b1;
                d.rdat = {24'h000000, reg_view(q, wb_adr_i)};
                if (wb_we_i && wb_sel_i[0]) begin
                    case (wb_adr_i)
                        OFS_DATA_LOW:  d.dat_lo = wb_dat_i[7:0];
                        OFS_DATA_HIGH: d.dat_hi = wb_dat_i[5:0];
                        OFS_ADDR_LOW:  d.adr_lo = wb_dat_i[7:0];
                        OFS_ADDR_HIGH: d.adr_hi = wb_dat_i[6:0];
                        OFS_CONTROL: begin
                            d.config_space_select = wb_dat_i[BIT_CFG_SELECT];
                            d.latch_load_only = wb_dat_i[BIT_LATCH_ONLY];
                            d.program_enable = wb_dat_i[BIT_PROG_EN];
                            d.err  = wb_dat_i[BIT_SEQ_ERROR];
                            // Erase select only changes while idle
                            if (!q.wr) begin
                                d.free = wb_dat_i[BIT_ERASE];
                            end
                            // Read start can only be set
                            d.rd = d.rd | wb_dat_i[BIT_READ_GO];
                            if (wb_dat_i[BIT_WRITE_GO]) begin
                                wr_try = 1'b1;
                                d.err  = 1'b1;
                                d.key  = KEY_NONE;
                                // Accept only when unlocked, enabled and idle
                                if (q.key == KEY_OPEN && q.program_enable && !q.wr) begin
                                    wr_go = 1'b1;
                                    d.wr  = 1'b1;
                                end
                            end
                        end
                        OFS_UNLOCK_KEY: begin
                            if (key_byte == KEY_FIRST) begin
                                d.key = KEY_HALF;
                            end else if (key_byte == KEY_SECOND && q.key == KEY_HALF) begin
                                d.key = KEY_OPEN;
                            end else begin
                                d.key = KEY_NONE;
                            end
                        end
                        default: begin
                            // Unmapped: write ignored
                        end
                    endcase
                end
            end
            // Operation sequencer
            case (q.fsm)
                ST_IDLE: begin
                    d.f_adr = {q.adr_hi, q.adr_lo};
                    if (q.wr) begin
                        d.fsm = ST_START;
                    end
                end
                ST_START: begin
                    if (q.free) begin
                        // Erase: whole row, latch-only ignored
                        if (!q.config_space_select) begin
                            d.f_erase = 1'b1;
                            d.f_adr   = {q.adr_hi, q.adr_lo[7:4], 4'h0};
                            d.arr     = 1'b1;
                        end
                        d.cnt = WAIT_W'(ROW_ERASE_CYCLES);
                        d.fsm = ST_WAIT;
                    end else if (q.config_space_select) begin
                        // Config space: only user IDs accept data
                        if ({q.adr_hi, q.adr_lo} <= CFG_USER_ID_LAST) begin
                            d.uid[q.adr_lo[1:0]] = {q.dat_hi, q.dat_lo};
                        end
                        d.fsm = ST_DONE;
                    end else begin
                        d.latch[q.adr_lo[3:0]] = {q.dat_hi, q.dat_lo};
                        if (q.latch_load_only) begin
                            d.fsm = ST_DONE;
                        end else begin
                            d.idx = 4'h0;
                            d.arr = 1'b1;
                            d.fsm = ST_PROG;
                        end
                    end
                end
                ST_PROG: begin
                    // Stream the row one latch per cycle
                    d.f_prog  = 1'b1;
                    d.f_adr   = {q.adr_hi, q.adr_lo[7:4], q.idx};
                    d.f_wdat  = q.latch[q.idx];
                    d.idx     = q.idx + 4'h1;
                    if (q.idx == 4'hF) begin
                        d.cnt = WAIT_W'(ROW_PROG_CYCLES);
                        d.fsm = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    d.cnt = q.cnt - WAIT_W'(1);
                    if (q.cnt <= WAIT_W'(1)) begin
                        d.fsm = ST_DONE;
                    end
                end
                ST_DONE: begin
                    d.wr   = 1'b0;
                    d.free = 1'b0;
                    if (q.arr) begin
                        d.latch = {ROW_WORDS{LATCH_BLANK}};
                        d.arr   = 1'b0;
                    end
                    d.fsm = ST_IDLE;
                end
                default: begin
                    d.fsm = ST_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flip-flops
    assign wb_dat_o      = q.rdat;
    assign wb_ack_o      = q.ack;
    assign flash_addr_o  = q.f_adr;
    assign flash_wdata_o = q.f_wdat;
    assign flash_prog_o  = q.f_prog;
    assign flash_erase_o = q.f_erase;
    assign busy_o        = q.wr;

    // Acknowledge is a single-cycle pulse while clock enable stays high; with clock enable low it holds
    a_ack_single_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Every start attempt raises the error flag
    a_err_on_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && wr_try |=> q.err)
        else $error("start attempt left error flag clear");

    // Read start clears after one enabled idle cycle
    a_read_self_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && q.rd && q.fsm == ST_IDLE && !(bus_req && wb_we_i) |=> !q.rd)
        else $error("read start not cleared");

    // Invalid config read returns zero
    a_cfg_read_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && q.rd && q.fsm == ST_IDLE && q.config_space_select && !cfg_readable({q.adr_hi, q.adr_lo})
        && !(bus_req && wb_we_i) |=> q.dat_lo == 8'h00 && q.dat_hi == 6'h00)
        else $error("invalid config read not zero");

    // High address read shows bit 7 set
    a_addr_high_view: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && bus_req && !wb_we_i && wb_adr_i == OFS_ADDR_HIGH |=> wb_dat_o[7])
        else $error("high address bit 7 not one");

    // High data read shows top bits clear
    a_data_high_view: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && bus_req && !wb_we_i && wb_adr_i == OFS_DATA_HIGH |=> wb_dat_o[7:6] == 2'h0)
        else $error("high data top bits not zero");

    // Disabled start changes nothing in the sequencer
    a_disabled_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && wr_try && !q.program_enable && !q.wr |=> !q.wr ##1 !flash_prog_o && !flash_erase_o)
        else $error("start accepted while disabled");

    // Latch-only load never programs
    a_latch_only_load: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && q.fsm == ST_START && q.latch_load_only && !q.free |=> q.fsm == ST_DONE && !flash_prog_o)
        else $error("latch-only start programmed the array");

    // Array operation completion clears start and erase select and blanks latches
    a_done_cleanup: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && q.fsm == ST_DONE && q.arr
        |=> !q.wr && !q.free && q.latch == {ROW_WORDS{LATCH_BLANK}})
        else $error("operation end left state behind");

    // Row programming enters the walk and pulses program on the next enabled cycle
    a_row_walk: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i && q.fsm == ST_START && !q.free && !q.config_space_select && !q.latch_load_only
        |=> q.fsm == ST_PROG ##1 (flash_prog_o || !ce_i))
        else $error("row program did not start walking");

endmodule : flash_self_write_control

// ### dv/tb_flash_self_write_control.sv
// Self-checking bench of the flash self-write sequencer
module tb_flash_self_write_control import flash_self_write_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk   = 1'b0;     // Bus clock
    logic        rst_b = 1'b0;     // Reset, active low
    logic        ce    = 1'b1;     // Clock enable
    logic        cyc   = 1'b0;     // Bus cycle
    logic        stb   = 1'b0;     // Bus strobe
    logic        we    = 1'b0;     // Bus direction
    logic [7:0]  adr   = 8'h00;    // Bus address
    logic [3:0]  sel   = 4'h0;     // Byte selects
    logic [31:0] wdat  = 32'h0;    // Bus write data
    logic [13:0] cfg1  = 14'h0;    // First config word
    logic [13:0] cfg2  = 14'h0;    // Second config word
    logic [31:0] dat_o;            // Bus read data
    logic        ack;              // Bus acknowledge
    logic [14:0] faddr;            // Array address
    logic [13:0] fwdata;           // Array write word
    logic        fprog;            // Word program pulse
    logic        ferase;           // Row erase pulse
    logic        busy;             // Operation running
    logic [13:0] mem [0:32767];    // Array model
    logic [13:0] uid [0:3];        // Expected user IDs
    integer      seed = 32'h65BD;  // Fixed random seed
    integer      fails = 0;        // Mismatch count
    integer      total_checks = 0; // Comparison count
    integer      nprog = 0;        // Program pulses seen
    integer      nerase = 0;       // Erase pulses seen

    flash_self_write_control i_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .flash_rdata_i(mem[faddr]),
        .config_word_one_i(cfg1), .config_word_two_i(cfg2), .flash_addr_o(faddr),
        .flash_wdata_o(fwdata), .flash_prog_o(fprog), .flash_erase_o(ferase), .busy_o(busy));

    // Clock of 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    // Array model: words take program pulses, rows take erase pulses
    always @(posedge clk) begin
        if (fprog === 1'b1) begin
            mem[faddr] <= fwdata;
            nprog++;
        end
        if (ferase === 1'b1) begin
            for (int i = 0; i < 16; i++) mem[{faddr[14:4], 4'(i)}] <= LATCH_BLANK;
            nerase++;
        end
    end

    // Compare and count
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Counts and verdict, then stop
    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // One classic bus cycle, held until ack is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        integer n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) fails++;
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        xfer(1'b1, a, d, t);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask : rd

    // Control byte from its fields
    function logic [31:0] ctl(input logic c, l, e, en, go, r);
        return {24'h0, 1'b0, c, l, e, 1'b0, en, go, r};
    endfunction : ctl

    // Address and data registers
    task load(input logic [14:0] a, input logic [13:0] d);
        wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
        wr(OFS_ADDR_HIGH, {25'h0, a[14:8]});
        wr(OFS_DATA_LOW, {24'h0, d[7:0]});
        wr(OFS_DATA_HIGH, {26'h0, d[13:8]});
    endtask : load

    // Optional key, start, wait for idle, then check the flags
    task op(input logic [31:0] cv, input bit key);
        integer n;
        logic [31:0] r;
        logic [31:0] e;
        n = 0;
        // Enable and mode settle first; the start write only sees the stored enable
        wr(OFS_CONTROL, cv & ~(32'h1 << BIT_WRITE_GO));
        // A refused start leaves erase select as written
        e = (key && cv[BIT_PROG_EN]) ? 32'h0 : 32'(cv[BIT_ERASE]);
        if (key) begin
            wr(OFS_UNLOCK_KEY, 32'h55);
            wr(OFS_UNLOCK_KEY, 32'hAA);
        end
        wr(OFS_CONTROL, cv);
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) fails++;
        rd(OFS_CONTROL, r);
        chk("error flag", 32'h1, 32'(r[BIT_SEQ_ERROR]));
        chk("start bit", 32'h0, 32'(r[BIT_WRITE_GO]));
        chk("erase bit", e, 32'(r[BIT_ERASE]));
    endtask : op

    // Fetch one word; data registers hold nonzero junk beforehand
    task rdw(input logic c, input logic [14:0] a, output logic [13:0] w);
        logic [31:0] lo, hi, r;
        load(a, 14'h3FFF);
        wr(OFS_CONTROL, ctl(c, 0, 0, 0, 0, 1));
        rd(OFS_CONTROL, r);
        chk("read start bit", 32'h0, 32'(r[BIT_READ_GO]));
        rd(OFS_DATA_LOW, lo);
        rd(OFS_DATA_HIGH, hi);
        chk("data high top", 32'h0, hi & 32'hFFFFFFC0);
        w = {hi[5:0], lo[7:0]};
    endtask : rdw

    // Expected word of configuration space
    function logic [13:0] cfg_exp(input logic [14:0] a);
        if (a < 15'h0004) return uid[a[1:0]];
        if (a == CFG_DEVICE_ID) return DEVICE_ID_WORD;
        if (a == CFG_CONFIG_ONE) return cfg1;
        if (a == CFG_CONFIG_TWO) return cfg2;
        return 14'h0;
    endfunction : cfg_exp

    // Sweep over configuration addresses, mapped and unmapped
    task cfg_sweep;
        logic [13:0] w;
        for (int a = 0; a < 11; a++) begin
            rdw(1'b1, 15'(a), w);
            chk("config word", 32'(cfg_exp(15'(a))), 32'(w));
        end
        $display("config sweep done");
    endtask : cfg_sweep

    // Watchdog against a hang
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        give_verdict;
    end

    // Main sequence
    initial begin
        logic [31:0] r, v;
        logic [13:0] w, d;
        logic [14:0] row;
        logic [13:0] exp_row [0:15];
        integer      np;
        for (int i = 0; i < 32768; i++) mem[i] = 14'($random(seed));
        for (int i = 0; i < 4; i++) uid[i] = LATCH_BLANK;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFS_ADDR_LOW, r);
        chk("addr low reset", 32'h00, r);
        rd(OFS_ADDR_HIGH, r);
        chk("addr high reset", 32'h80, r);
        rd(OFS_CONTROL, r);
        chk("control reset", 32'h80, r);
        $display("reset values done");
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(OFS_DATA_LOW, v); rd(OFS_DATA_LOW, r);
            chk("data low", v & 32'hFF, r);
            wr(OFS_DATA_HIGH, v); rd(OFS_DATA_HIGH, r);
            chk("data high", v & 32'h3F, r);
            wr(OFS_ADDR_LOW, v); rd(OFS_ADDR_LOW, r);
            chk("addr low", v & 32'hFF, r);
            wr(OFS_ADDR_HIGH, v); rd(OFS_ADDR_HIGH, r);
            chk("addr high", (v & 32'h7F) | 32'h80, r);
        end
        rd(8'h18, r);
        chk("unmapped", 32'h0, r);
        rd(OFS_UNLOCK_KEY, r);
        chk("key read", 32'h0, r);
        $display("register access done");
        for (int k = 0; k < 6; k++) begin
            row = 15'($random(seed));
            rdw(1'b0, row, w);
            chk("array word", 32'(mem[row]), 32'(w));
        end
        $display("array reads done");
        cfg1 <= 14'($random(seed));
        cfg2 <= 14'($random(seed));
        cfg_sweep;
        d = 14'($random(seed));
        load(15'h0002, d);
        op(ctl(1, 0, 0, 1, 1, 0), 1'b1);
        uid[2] = d;
        load(CFG_DEVICE_ID, 14'h0ABC);
        op(ctl(1, 0, 0, 1, 1, 0), 1'b1);
        cfg_sweep;
        row = {11'($random(seed)), 4'h0};
        load(row | 15'h0007, 14'h0);
        op(ctl(0, 1, 1, 1, 1, 0), 1'b1);
        chk("erase pulses", 32'd1, nerase);
        for (int i = 0; i < 16; i++) chk("erased", 32'h3FFF, 32'(mem[row + 15'(i)]));
        $display("erase done");
        for (int i = 0; i < 16; i++) begin
            exp_row[i] = (i == 5) ? LATCH_BLANK : 14'($random(seed));
            if (i != 5) begin
                load(row + 15'(i), exp_row[i]);
                op(ctl(0, i != 15, 0, 1, 1, 0), 1'b1);
                chk("program pulses", (i == 15) ? 32'd16 : 32'd0, nprog);
            end
        end
        for (int i = 0; i < 16; i++) begin
            rdw(1'b0, row + 15'(i), w);
            chk("verify word", 32'(exp_row[i]), 32'(w));
        end
        load(row ^ 15'h4000, 14'h0123);
        op(ctl(0, 0, 0, 1, 1, 0), 1'b1);
        rdw(1'b0, (row ^ 15'h4000) + 15'h1, w);
        chk("blank latch", 32'h3FFF, 32'(w));
        $display("row program done");
        np = nprog;
        load(row + 15'h3, 14'h0000);
        op(ctl(0, 0, 0, 0, 1, 0), 1'b1);
        op(ctl(0, 0, 1, 0, 1, 0), 1'b1);
        op(ctl(0, 0, 0, 1, 1, 0), 1'b0);
        chk("inhibited pulses", np, nprog);
        chk("inhibited erase", 32'd1, nerase);
        rdw(1'b0, row + 15'h3, w);
        chk("inhibited word", 32'(exp_row[3]), 32'(w));
        $display("inhibit done");
        // Clock enable low holds a pending request until it returns
        ce <= 1'b0;
        fork
            wr(OFS_ADDR_LOW, 32'hC3);
            begin
                repeat (4) @(posedge clk);
                chk("frozen ack", 32'h0, 32'(ack));
                ce <= 1'b1;
            end
        join
        rd(OFS_ADDR_LOW, r);
        chk("addr low after freeze", 32'hC3, r);
        $display("clock enable done");
        wr(OFS_ADDR_LOW, 32'h5A);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(OFS_ADDR_LOW, r);
        chk("addr low second reset", 32'h00, r);
        $display("second reset done");
        give_verdict;
    end

endmodule : tb_flash_self_write_control
